//--- logic/d2pci_cfg.svh
// Constants of the DDR2 pin control interface
`ifndef D2PCI_CFG_SVH
`define D2PCI_CFG_SVH

`define D2PCI_BANKS        4
`define D2PCI_BA_W         2
`define D2PCI_ADDR_W       14
`define D2PCI_LANES        2
`define D2PCI_LANE_W       8
`define D2PCI_DQ_W         16
`define D2PCI_BA_MR        2'h0
`define D2PCI_BA_EMR1      2'h1
`define D2PCI_A_ALLBANK    10
`define D2PCI_A_MODEONLY   12
`define D2PCI_EMR_DQSN_OFF 10
`define D2PCI_EMR_RDQS_EN  11
`define D2PCI_EMR_TERM_LO  2
`define D2PCI_EMR_TERM_HI  6
`define D2PCI_EMR_RST      14'h0000
`define D2PCI_CTL_IDLE     4'hf
`define D2PCI_ST_W         8

`endif

//--- logic/d2pci_pin_ctrl.sv
// DDR2 device pin control: command capture, power states, ODT, strobes
// Operation
// - Address and control pins are captured on the rising command clock.
// - Read data is launched on both clock crossings, two beats a cycle.
// - CKE high runs clocks, input buffers and drivers; low stops them.
// - CKE low enters precharge power-down or self refresh if idle, else active.
// - CKE sampled for entries and PD exit; self-refresh exit seen asynchronously.
// - In power-down only clock, ODT and CKE input buffers stay on.
// - In self refresh only the CKE input buffer stays on.
// - A command with chip select high is ignored.
// - Commands decode from select, row, column strobes and write enable.
// - ODT high with termination enabled terminates DQ, DQS, RDQS, DM.
// - Wide part terminates all DQ, both strobe pairs and both masks.
// - With termination disabled in the extended register, ODT is ignored.
// - Write beats with the mask high are discarded.
// - The mask is sampled on both strobe edges, one bit per beat.
// - Narrow part with read strobe on drives RDQS like DQS, no masking.
// - Narrow part picks mask or read strobe on the shared pin by mode.
// - Wide part uses A12 only for mode register setting.
// - Bank address picks target bank and mode or extended register.
// - Precharge closes one bank with A10 low, all with A10 high.
// - Read strobes are edge aligned; write strobes arrive centred.
// - Extended register bit A10 turns complementary strobes off.
`timescale 1ns/100ps
`default_nettype none
`include "d2pci_cfg.svh"

module d2pci_pin_ctrl (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ck,
  input  wire logic                         cke,
  input  wire d2pci_pkg::d2pci_ctl_t        ctl,
  input  wire logic [`D2PCI_BA_W-1:0]       ba,
  input  wire logic [`D2PCI_ADDR_W-1:0]     addr,
  input  wire logic                         odt,
  input  wire logic                         wideStrap,
  input  wire logic                         rdValid,
  input  wire logic [`D2PCI_DQ_W-1:0]       rdRise,
  input  wire logic [`D2PCI_DQ_W-1:0]       rdFall,
  input  wire logic [`D2PCI_LANES-1:0]      dqsIn,
  input  wire logic [`D2PCI_DQ_W-1:0]       dqIn,
  input  wire logic [`D2PCI_LANES-1:0]      dmIn,
  output logic                              ckBufEn,
  output logic                              odtBufEn,
  output logic                              cmdBufEn,
  output logic                              dqBufEn,
  output logic [`D2PCI_LANES-1:0]           termDq,
  output logic [`D2PCI_LANES-1:0]           termDqs,
  output logic [`D2PCI_LANES-1:0]           termDm,
  output logic                              termRdqs,
  output logic [`D2PCI_DQ_W-1:0]            dqRise,
  output logic [`D2PCI_DQ_W-1:0]            dqFall,
  output logic                              dqOe,
  output logic [`D2PCI_LANES-1:0]           dqsOe,
  output logic [`D2PCI_LANES-1:0]           dqsNOe,
  output logic                              rdqsOe,
  output var d2pci_pkg::d2pci_beat_t        wrBeatRise [`D2PCI_LANES],
  output var d2pci_pkg::d2pci_beat_t        wrBeatFall [`D2PCI_LANES],
  output logic                              cmdValid,
  output var d2pci_pkg::d2pci_cmd_word_t    cmdWord,
  output var d2pci_pkg::d2pci_pwr_t         pwrState,
  output logic [`D2PCI_BANKS-1:0]           bankOpen,
  output logic                              termActive
);

  logic [1:0]                  ckRstSync;
  logic                        ckRst_n;
  d2pci_pkg::d2pci_ctl_t       ctlQ;
  logic [`D2PCI_BA_W-1:0]      baQ;
  logic [`D2PCI_ADDR_W-1:0]    addrQ;
  logic                        ckeQ;
  logic                        ckePrev;
  logic                        odtQ;
  logic                        wide;
  logic                        wideDone;
  d2pci_pkg::d2pci_cmd_t       cmdDec;
  d2pci_pkg::d2pci_cmd_t       cmdEff;
  d2pci_pkg::d2pci_pwr_t       pwr;
  d2pci_pkg::d2pci_pwr_t       next_pwr;
  logic [`D2PCI_BANKS-1:0]     bankOpenCk;
  logic                        allIdle;
  logic [`D2PCI_ADDR_W-1:0]    emr;
  logic                        termEnable;
  logic                        dqsNOff;
  logic                        rdqsEn;
  logic                        termOn;
  logic                        drvOk;
  logic                        rdGo;
  logic [`D2PCI_DQ_W-1:0]      rdFallHold;
  logic [`D2PCI_LANES-1:0]     laneWin;
  logic [`D2PCI_LANES-1:0]     laneMaskOff;
  d2pci_pkg::d2pci_cmd_word_t  cmdHold;
  d2pci_pkg::d2pci_cmd_word_t  next_word;
  logic                        cmdTog;
  logic [2:0]                  cmdTogSync;
  logic [`D2PCI_ST_W-1:0]      stLevel;
  logic [`D2PCI_ST_W-1:0]      stSync0;
  logic [`D2PCI_ST_W-1:0]      stSync1;

  // Reset for the link side: asserted at once, released on the link clock
  always_ff @(posedge ck or negedge rst_n) begin
    if (!rst_n) begin
      ckRstSync <= 2'h0;
    end else begin
      ckRstSync <= {ckRstSync[0], 1'h1};
    end
  end
  assign ckRst_n = ckRstSync[1];

  // Pins are registered at the clock crossing and read only from here, except cke, which the clock receiver also reads directly
  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      ctlQ    <= `D2PCI_CTL_IDLE;
      baQ     <= 2'h0;
      addrQ   <= 14'h0000;
      ckeQ    <= 1'h0;
      ckePrev <= 1'h0;
      odtQ    <= 1'h0;
    end else begin
      ctlQ    <= ctl;
      baQ     <= ba;
      addrQ   <= addr;
      ckeQ    <= cke;
      ckePrev <= ckeQ;
      odtQ    <= odt;
    end
  end

  // Organisation strap is caught once, just after reset release
  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      wide     <= 1'h0;
      wideDone <= 1'h0;
    end else if (!wideDone) begin
      wide     <= wideStrap;
      wideDone <= 1'h1;
    end
  end

  always_comb begin
    cmdDec = d2pci_pkg::CMD_NOP;
    if (ctlQ.csN) begin
      cmdDec = d2pci_pkg::CMD_DESEL;
    end else begin
      case ({ctlQ.rasN, ctlQ.casN, ctlQ.weN})
        3'h0:    cmdDec = d2pci_pkg::CMD_MRS;
        3'h1:    cmdDec = d2pci_pkg::CMD_REF;
        3'h2:    cmdDec = d2pci_pkg::CMD_PRE;
        3'h3:    cmdDec = d2pci_pkg::CMD_ACT;
        3'h4:    cmdDec = d2pci_pkg::CMD_WR;
        3'h5:    cmdDec = d2pci_pkg::CMD_RD;
        default: cmdDec = d2pci_pkg::CMD_NOP;
      endcase
    end
  end

  // Command buffers are off outside the active state
  assign cmdEff = (pwr == d2pci_pkg::PWR_ACTIVE && ckePrev) ?
                  cmdDec : d2pci_pkg::CMD_DESEL;

  generate
    for (genvar b = 0; b < `D2PCI_BANKS; b++) begin : g_bank
      always_ff @(posedge ck or negedge ckRst_n) begin
        if (!ckRst_n) begin
          bankOpenCk[b] <= 1'h0;
        end else if (cmdEff == d2pci_pkg::CMD_ACT &&
                     baQ == `D2PCI_BA_W'(b)) begin
          bankOpenCk[b] <= 1'h1;
        end else if (cmdEff == d2pci_pkg::CMD_PRE &&
                     (addrQ[`D2PCI_A_ALLBANK] ||
                      baQ == `D2PCI_BA_W'(b))) begin
          bankOpenCk[b] <= 1'h0;
        end
      end
    end
  endgenerate
  assign allIdle = ~|bankOpenCk;

  always_comb begin
    next_pwr = pwr;
    case (pwr)
      d2pci_pkg::PWR_ACTIVE: begin
        if (ckePrev && !ckeQ) begin
          if (cmdEff == d2pci_pkg::CMD_REF && allIdle) begin
            next_pwr = d2pci_pkg::PWR_SELF_REF;
          end else if (allIdle) begin
            next_pwr = d2pci_pkg::PWR_PRE_PD;
          end else begin
            next_pwr = d2pci_pkg::PWR_ACT_PD;
          end
        end
      end
      d2pci_pkg::PWR_PRE_PD,
      d2pci_pkg::PWR_ACT_PD: begin
        if (ckeQ) begin
          next_pwr = d2pci_pkg::PWR_ACTIVE;
        end
      end
      d2pci_pkg::PWR_SELF_REF: begin
        if (ckeQ) begin
          next_pwr = d2pci_pkg::PWR_ACTIVE;
        end
      end
      default: next_pwr = d2pci_pkg::PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      pwr <= d2pci_pkg::PWR_ACTIVE;
    end else begin
      pwr <= next_pwr;
    end
  end

  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      emr <= `D2PCI_EMR_RST;
    end else if (cmdEff == d2pci_pkg::CMD_MRS &&
                 baQ == `D2PCI_BA_EMR1) begin
      emr <= addrQ;
    end
  end

  assign termEnable = emr[`D2PCI_EMR_TERM_HI] | emr[`D2PCI_EMR_TERM_LO];
  assign dqsNOff    = emr[`D2PCI_EMR_DQSN_OFF];
  assign rdqsEn     = emr[`D2PCI_EMR_RDQS_EN] & ~wide;
  assign termOn     = odtQ & termEnable &
                      (pwr != d2pci_pkg::PWR_SELF_REF);

  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      termDq   <= 2'h0;
      termDqs  <= 2'h0;
      termDm   <= 2'h0;
      termRdqs <= 1'h0;
    end else begin
      termDq   <= {wide & termOn, termOn};
      termDqs  <= {wide & termOn, termOn};
      termDm   <= {wide & termOn, termOn & ~rdqsEn};
      termRdqs <= termOn & rdqsEn;
    end
  end

  // A rising CKE wakes the clock receiver with no clock running
  always_ff @(posedge ck or negedge ckRst_n or posedge cke) begin
    if (!ckRst_n) begin
      ckBufEn <= 1'h1;
    end else if (cke) begin
      ckBufEn <= 1'h1;
    end else begin
      ckBufEn <= next_pwr != d2pci_pkg::PWR_SELF_REF;
    end
  end

  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      odtBufEn <= 1'h1;
      cmdBufEn <= 1'h1;
      dqBufEn  <= 1'h1;
    end else begin
      odtBufEn <= next_pwr != d2pci_pkg::PWR_SELF_REF;
      cmdBufEn <= next_pwr == d2pci_pkg::PWR_ACTIVE;
      dqBufEn  <= next_pwr == d2pci_pkg::PWR_ACTIVE;
    end
  end

  // Drivers need CKE high; a read cut by CKE is the controller's fault
  assign drvOk = (pwr == d2pci_pkg::PWR_ACTIVE) && ckeQ;
  assign rdGo  = rdValid & drvOk;

  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      dqRise     <= 16'h0000;
      rdFallHold <= 16'h0000;
      dqOe       <= 1'h0;
      dqsOe      <= 2'h0;
      dqsNOe     <= 2'h0;
      rdqsOe     <= 1'h0;
    end else begin
      dqRise     <= rdRise;
      rdFallHold <= rdFall;
      dqOe       <= rdGo;
      dqsOe      <= {wide & rdGo, rdGo};
      dqsNOe     <= {wide & rdGo, rdGo} & {2{~dqsNOff}};
      rdqsOe     <= rdGo & rdqsEn;
    end
  end

  // Falling beat leaves on the falling crossing, half a cycle later
  always_ff @(negedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      dqFall <= 16'h0000;
    end else begin
      dqFall <= rdFallHold;
    end
  end

  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      laneWin     <= 2'h0;
      laneMaskOff <= 2'h0;
    end else begin
      laneWin     <= {wide, 1'h1} & {2{next_pwr ==
                     d2pci_pkg::PWR_ACTIVE}};
      laneMaskOff <= {1'h0, rdqsEn};
    end
  end

  generate
    for (genvar l = 0; l < `D2PCI_LANES; l++) begin : g_lane
      d2pci_write_lane u_lane (
        .dqs      (dqsIn[l]),
        .rst_n    (rst_n),
        .winOpen  (laneWin[l]),
        .maskOff  (laneMaskOff[l]),
        .dq       (dqIn[l*`D2PCI_LANE_W +: `D2PCI_LANE_W]),
        .dm       (dmIn[l]),
        .beatRise (wrBeatRise[l]),
        .beatFall (wrBeatFall[l])
      );
    end
  endgenerate

  always_comb begin
    next_word          = '0;
    next_word.cmd      = cmdEff;
    next_word.bank     = baQ;
    next_word.addr     = addrQ;
    next_word.allBanks = (cmdEff == d2pci_pkg::CMD_PRE) &
                         addrQ[`D2PCI_A_ALLBANK];
    if (wide && cmdEff != d2pci_pkg::CMD_MRS) begin
      next_word.addr[`D2PCI_A_MODEONLY] = 1'h0;
    end
  end

  // Word stays put until the next command, so a toggle is enough
  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      cmdHold <= '0;
      cmdTog  <= 1'h0;
    end else if (cmdEff != d2pci_pkg::CMD_DESEL &&
                 cmdEff != d2pci_pkg::CMD_NOP) begin
      cmdHold <= next_word;
      cmdTog  <= ~cmdTog;
    end
  end

  // Power bits are one-hot and always pass through active, so each
  // bit may cross on its own
  always_ff @(posedge ck or negedge ckRst_n) begin
    if (!ckRst_n) begin
      stLevel <= 8'h00;
    end else begin
      stLevel <= {next_pwr == d2pci_pkg::PWR_PRE_PD,
                  next_pwr == d2pci_pkg::PWR_ACT_PD,
                  next_pwr == d2pci_pkg::PWR_SELF_REF,
                  termOn, bankOpenCk};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdTogSync <= 3'h0;
      stSync0    <= 8'h00;
      stSync1    <= 8'h00;
    end else begin
      cmdTogSync <= {cmdTogSync[1:0], cmdTog};
      stSync0    <= stLevel;
      stSync1    <= stSync0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdValid <= 1'h0;
      cmdWord  <= '0;
    end else begin
      cmdValid <= cmdTogSync[2] ^ cmdTogSync[1];
      if (cmdTogSync[2] ^ cmdTogSync[1]) begin
        cmdWord <= cmdHold;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrState   <= d2pci_pkg::PWR_ACTIVE;
      bankOpen   <= 4'h0;
      termActive <= 1'h0;
    end else begin
      bankOpen   <= stSync1[3:0];
      termActive <= stSync1[4];
      if (stSync1[5]) begin
        pwrState <= d2pci_pkg::PWR_SELF_REF;
      end else if (stSync1[6]) begin
        pwrState <= d2pci_pkg::PWR_ACT_PD;
      end else if (stSync1[7]) begin
        pwrState <= d2pci_pkg::PWR_PRE_PD;
      end else begin
        pwrState <= d2pci_pkg::PWR_ACTIVE;
      end
    end
  end

endmodule
`default_nettype wire

//--- logic/d2pci_pkg.sv
// Types shared by the DDR2 pin control interface
`include "d2pci_cfg.svh"

package d2pci_pkg;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_DESEL
  } d2pci_cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
  } d2pci_pwr_t;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } d2pci_ctl_t;

  typedef struct packed {
    d2pci_cmd_t              cmd;
    logic [`D2PCI_BA_W-1:0]   bank;
    logic                    allBanks;
    logic [`D2PCI_ADDR_W-1:0] addr;
  } d2pci_cmd_word_t;

  typedef struct packed {
    logic [`D2PCI_LANE_W-1:0] data;
    logic                    keep;
  } d2pci_beat_t;

endpackage

//--- logic/d2pci_write_lane.sv
// One write byte lane: data and mask captured on both strobe edges
`timescale 1ns/100ps
`default_nettype none
`include "d2pci_cfg.svh"

module d2pci_write_lane (
  input  wire logic                     dqs,
  input  wire logic                     rst_n,
  input  wire logic                     winOpen,
  input  wire logic                     maskOff,
  input  wire logic [`D2PCI_LANE_W-1:0] dq,
  input  wire logic                     dm,
  output var  d2pci_pkg::d2pci_beat_t   beatRise,
  output var  d2pci_pkg::d2pci_beat_t   beatFall
);

  logic [1:0] winSync;
  logic [1:0] offSync;

  // Levels from the command clock; the strobe preamble gives the edges
  always_ff @(posedge dqs or negedge rst_n) begin
    if (!rst_n) begin
      winSync <= 2'h0;
      offSync <= 2'h0;
    end else begin
      winSync <= {winSync[0], winOpen};
      offSync <= {offSync[0], maskOff};
    end
  end

  always_ff @(posedge dqs or negedge rst_n) begin
    if (!rst_n) begin
      beatRise <= '0;
    end else begin
      beatRise.data <= dq;
      beatRise.keep <= winSync[1] & ~(dm & ~offSync[1]);
    end
  end

  always_ff @(negedge dqs or negedge rst_n) begin
    if (!rst_n) begin
      beatFall <= '0;
    end else begin
      beatFall.data <= dq;
      beatFall.keep <= winSync[1] & ~(dm & ~offSync[1]);
    end
  end

endmodule
`default_nettype wire

//--- test/d2pci_ctrl_model.sv
// Controller-side model driving DDR2 clock, command and write pins
`timescale 1ns/100ps
`default_nettype none

module d2pci_ctrl_model (
  output var logic                   ck,
  output var logic                   cke,
  output var d2pci_pkg::d2pci_ctl_t  ctl,
  output var logic [1:0]             ba,
  output var logic [13:0]            addr,
  output var logic                   odt,
  output var logic [1:0]             dqsIn,
  output var logic [15:0]            dqIn,
  output var logic [1:0]             dmIn
);
  initial begin
    ck = 1'b0;
    cke = 1'b1;
    ctl = 4'hf;
    ba = 2'h0;
    addr = 14'h0;
    odt = 1'b0;
    dqsIn = 2'h0;
    dqIn = 16'h0;
    dmIn = 2'h0;
    #7;
    forever #62.5 ck = ~ck;
  end

  // Released address is scrambled so a stale capture cannot pass
  task automatic issue(input logic [3:0] code, input logic [1:0] bank,
                       input logic [13:0] a, input logic ckeLvl);
    @(posedge ck);
    ctl <= d2pci_pkg::d2pci_ctl_t'(code);
    ba <= bank;
    addr <= a;
    cke <= ckeLvl;
    @(posedge ck);
    ctl <= d2pci_pkg::d2pci_ctl_t'(4'hf);
    ba <= ~bank;
    addr <= ~a;
  endtask

  task automatic set_pins(input logic ckeLvl, input logic odtLvl);
    @(posedge ck);
    cke <= ckeLvl;
    odt <= odtLvl;
  endtask

  // Two-pulse preamble, then four beats; cke is left high throughout
  task automatic write_burst(input logic [63:0] d, input logic [7:0] m);
    repeat (2) begin
      #20 dqsIn = 2'h3;
      #20 dqsIn = 2'h0;
    end
    for (int i = 0; i < 4; i++) begin
      dqIn = d[i*16 +: 16];
      dmIn = m[i*2 +: 2];
      #20 dqsIn = ~dqsIn;
      #20;
    end
    dqIn = ~dqIn;
    dmIn = ~dmIn;
  endtask
endmodule
`default_nettype wire

//--- test/d2pci_pin_ctrl_assertions.sv
// Port-level assertions for the DDR2 pin control block
`timescale 1ns/100ps
`default_nettype none
`include "d2pci_cfg.svh"

module d2pci_pin_ctrl_assertions (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       ck,
  input wire logic                       cke,
  input wire logic                       odt,
  input wire logic                       wideStrap,
  input wire logic                       rdValid,
  input wire logic [`D2PCI_DQ_W-1:0]     rdRise,
  input wire logic                       ckBufEn,
  input wire logic                       odtBufEn,
  input wire logic                       cmdBufEn,
  input wire logic                       dqBufEn,
  input wire logic [`D2PCI_LANES-1:0]    termDq,
  input wire logic [`D2PCI_LANES-1:0]    termDqs,
  input wire logic [`D2PCI_LANES-1:0]    termDm,
  input wire logic [`D2PCI_DQ_W-1:0]     dqRise,
  input wire logic                       dqOe,
  input wire logic                       cmdValid,
  input wire d2pci_pkg::d2pci_cmd_word_t cmdWord,
  input wire d2pci_pkg::d2pci_pwr_t      pwrState
);
  a_read_launch: assert property (@(posedge ck) disable iff (!rst_n)
    dqOe |-> $past(rdValid) && $past(cke, 2) && dqRise == $past(rdRise))
    else $error("read drive without a matching read beat");
  a_pd_buffers: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pwrState == d2pci_pkg::PWR_ACT_PD) |->
      ckBufEn && odtBufEn && !cmdBufEn && !dqBufEn)
    else $error("power-down buffer enables wrong");
  a_sr_buffers: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pwrState == d2pci_pkg::PWR_SELF_REF) |->
      !ckBufEn && !odtBufEn && !cmdBufEn && !dqBufEn)
    else $error("self refresh buffer enables wrong");
  a_term_odt: assert property (@(posedge ck) disable iff (!rst_n)
    (|termDq) |-> $past(odt, 2))
    else $error("termination without odt");
  a_term_wide: assert property (@(posedge ck) disable iff (!rst_n)
    wideStrap |-> termDqs == termDq && termDm == termDq)
    else $error("wide part termination lanes differ");
  a_cmd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    cmdValid |=> !cmdValid)
    else $error("command pulse longer than one cycle");
  a_pre_all: assert property (@(posedge clk) disable iff (!rst_n)
    cmdValid && cmdWord.cmd == d2pci_pkg::CMD_PRE |->
      cmdWord.allBanks == cmdWord.addr[`D2PCI_A_ALLBANK])
    else $error("precharge all flag wrong");
  a_addr_top: assert property (@(posedge clk) disable iff (!rst_n)
    cmdValid && wideStrap && cmdWord.cmd != d2pci_pkg::CMD_MRS |->
      !cmdWord.addr[`D2PCI_A_MODEONLY])
    else $error("mode-only address bit used");
endmodule

bind d2pci_pin_ctrl d2pci_pin_ctrl_assertions chk (
  .clk(clk), .rst_n(rst_n), .ck(ck), .cke(cke), .odt(odt),
  .wideStrap(wideStrap), .rdValid(rdValid), .rdRise(rdRise),
  .ckBufEn(ckBufEn), .odtBufEn(odtBufEn), .cmdBufEn(cmdBufEn),
  .dqBufEn(dqBufEn), .termDq(termDq), .termDqs(termDqs), .termDm(termDm),
  .dqRise(dqRise), .dqOe(dqOe), .cmdValid(cmdValid), .cmdWord(cmdWord),
  .pwrState(pwrState)
);
`default_nettype wire

//--- test/d2pci_pin_ctrl_tb.sv
// Self-checking bench for the DDR2 pin control block
`timescale 1ns/100ps
`default_nettype none

module d2pci_pin_ctrl_tb;
  logic                  clk, rst_n, wideStrap, rdValid, ck, cke, odt;
  logic                  ckBufEn, odtBufEn, cmdBufEn, dqBufEn, termRdqs;
  logic                  dqOe, rdqsOe, cmdValid, termActive;
  logic [1:0]            ba, dqsIn, dmIn, termDq, termDqs, termDm;
  logic [1:0]            dqsOe, dqsNOe;
  logic [3:0]            bankOpen;
  logic [13:0]           addr;
  logic [15:0]           rdRise, rdFall, dqIn, dqRise, dqFall;
  d2pci_pkg::d2pci_ctl_t      ctl;
  d2pci_pkg::d2pci_beat_t     wrBeatRise [2];
  d2pci_pkg::d2pci_beat_t     wrBeatFall [2];
  d2pci_pkg::d2pci_cmd_word_t cmdWord;
  d2pci_pkg::d2pci_pwr_t      pwrState;
  int                    miscompares, checked;

  d2pci_ctrl_model ctrl (.ck(ck), .cke(cke), .ctl(ctl), .ba(ba),
    .addr(addr), .odt(odt), .dqsIn(dqsIn), .dqIn(dqIn), .dmIn(dmIn));

  d2pci_pin_ctrl DUT (.clk(clk), .rst_n(rst_n), .ck(ck), .cke(cke),
    .ctl(ctl), .ba(ba), .addr(addr), .odt(odt), .wideStrap(wideStrap),
    .rdValid(rdValid), .rdRise(rdRise), .rdFall(rdFall), .dqsIn(dqsIn),
    .dqIn(dqIn), .dmIn(dmIn), .ckBufEn(ckBufEn), .odtBufEn(odtBufEn),
    .cmdBufEn(cmdBufEn), .dqBufEn(dqBufEn), .termDq(termDq),
    .termDqs(termDqs), .termDm(termDm), .termRdqs(termRdqs),
    .dqRise(dqRise), .dqFall(dqFall), .dqOe(dqOe), .dqsOe(dqsOe),
    .dqsNOe(dqsNOe), .rdqsOe(rdqsOe), .wrBeatRise(wrBeatRise),
    .wrBeatFall(wrBeatFall), .cmdValid(cmdValid), .cmdWord(cmdWord),
    .pwrState(pwrState), .bankOpen(bankOpen), .termActive(termActive));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic compare(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Window of 40 clk covers the 3..5 cycle answer plus the ck stage
  task automatic step(input logic [3:0] code, input logic [1:0] bank,
                      input logic [13:0] a, input logic hit,
                      input d2pci_pkg::d2pci_cmd_t cmd,
                      input logic [3:0] open);
    logic seen;
    logic [13:0] expAddr;
    seen = 1'b0;
    expAddr = a;
    if (wideStrap && cmd != d2pci_pkg::CMD_MRS) expAddr[12] = 1'b0;
    ctrl.issue(code, bank, a, 1'b1);
    repeat (40) begin
      @(posedge clk);
      #1;
      if (cmdValid === 1'b1) begin
        seen = 1'b1;
        if (hit) compare("command", cmd, cmdWord.cmd);
        if (hit) compare("bank", bank, cmdWord.bank);
        if (hit) compare("addr", expAddr, cmdWord.addr);
      end
    end
    compare("command pulse", hit, seen);
    compare("bankOpen", open, bankOpen);
    if (hit && !seen) finish_test();
  endtask

  task automatic power(input logic ckeLvl, input d2pci_pkg::d2pci_pwr_t st,
                       input logic [3:0] bufs);
    ctrl.set_pins(ckeLvl, 1'b0);
    repeat (2) @(posedge ck);
    repeat (8) @(posedge clk);
    #1;
    compare("pwrState", st, pwrState);
    compare("buffers", bufs, {ckBufEn, odtBufEn, cmdBufEn, dqBufEn});
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    wideStrap = 1'b1;
    rdValid = 1'b0;
    rdRise = 16'h0;
    rdFall = 16'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ck);
    compare("buffers", 4'hf, {ckBufEn, odtBufEn, cmdBufEn, dqBufEn});
    step(4'h3, 2'h2, 14'h1abc, 1'b1, d2pci_pkg::CMD_ACT, 4'h4);
    step(4'hb, 2'h1, 14'h0000, 1'b0, d2pci_pkg::CMD_ACT, 4'h4);
    step(4'h3, 2'h1, 14'h0000, 1'b1, d2pci_pkg::CMD_ACT, 4'h6);
    step(4'h2, 2'h1, 14'h0000, 1'b1, d2pci_pkg::CMD_PRE, 4'h4);
    step(4'h2, 2'h0, 14'h0400, 1'b1, d2pci_pkg::CMD_PRE, 4'h0);
    $display("test commands done");
    // Termination on with strobe complements off, then a read
    step(4'h0, 2'h1, 14'h0404, 1'b1, d2pci_pkg::CMD_MRS, 4'h0);
    ctrl.set_pins(1'b1, 1'b1);
    repeat (3) @(posedge ck);
    #1;
    compare("termination", 8'hfd,
            {termDq, termDqs, termDm, termRdqs, termActive});
    @(posedge ck);
    rdValid <= 1'b1;
    rdRise <= 16'ha55a;
    rdFall <= 16'h5aa5;
    @(posedge ck);
    rdValid <= 1'b0;
    #1;
    compare("read drive", 6'h38, {dqOe, dqsOe, dqsNOe, rdqsOe});
    compare("dqRise", 16'ha55a, dqRise);
    @(negedge ck);
    #1;
    compare("dqFall", 16'h5aa5, dqFall);
    step(4'h0, 2'h1, 14'h0000, 1'b1, d2pci_pkg::CMD_MRS, 4'h0);
    repeat (2) @(posedge ck);
    #1;
    compare("termination", 8'h00,
            {termDq, termDqs, termDm, termRdqs, termActive});
    ctrl.set_pins(1'b1, 1'b0);
    $display("test termination and read done");
    ctrl.write_burst(64'h4444_3333_2222_1111, 8'h50);
    compare("rise beats", 10'h0ce, {wrBeatRise[1], wrBeatRise[0].keep});
    compare("fall beats", 18'h11288, {wrBeatFall[1], wrBeatFall[0]});
    $display("test write done");
    step(4'h3, 2'h3, 14'h0000, 1'b1, d2pci_pkg::CMD_ACT, 4'h8);
    power(1'b0, d2pci_pkg::PWR_ACT_PD, 4'hc);
    power(1'b1, d2pci_pkg::PWR_ACTIVE, 4'hf);
    step(4'h2, 2'h0, 14'h0400, 1'b1, d2pci_pkg::CMD_PRE, 4'h0);
    ctrl.issue(4'h1, 2'h0, 14'h0000, 1'b0);
    power(1'b0, d2pci_pkg::PWR_SELF_REF, 4'h0);
    ctrl.set_pins(1'b1, 1'b0);
    #1;
    compare("ckBufEn", 1'b1, ckBufEn);
    power(1'b1, d2pci_pkg::PWR_ACTIVE, 4'hf);
    $display("test power states done");
    // Second reset in mid-run brings the part up in its narrow form
    rst_n <= 1'b0;
    wideStrap <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ck);
    step(4'h0, 2'h1, 14'h0804, 1'b1, d2pci_pkg::CMD_MRS, 4'h0);
    ctrl.set_pins(1'b1, 1'b1);
    repeat (3) @(posedge ck);
    #1;
    compare("x8 termination", 8'h53,
            {termDq, termDqs, termDm, termRdqs, termActive});
    @(posedge ck);
    rdValid <= 1'b1;
    @(posedge ck);
    rdValid <= 1'b0;
    #1;
    compare("x8 read drive", 6'h2b, {dqOe, dqsOe, dqsNOe, rdqsOe});
    // Masks are high on the lower lane, which must keep its beats
    ctrl.write_burst(64'h4444_3333_2222_1111, 8'h55);
    compare("x8 fall beats", 18'h11089,
            {wrBeatFall[1], wrBeatFall[0]});
    $display("test narrow part done");
    finish_test();
  end
endmodule
`default_nettype wire
